// ===== hdl/cwfc_consts.svh
`ifndef CWFC_CONSTS_SVH
`define CWFC_CONSTS_SVH
// ==================================================================
// Word addresses inside the EPC and TAG_IDENTIFIER_BANK banks
`define CWFC_CFG_WORD_ADDR   16'h0200
// TAG_IDENTIFIER_BANK word holding the configuration-word indicator (bit address 14h)
`define CWFC_TID_IND_WORD    16'h0001
`define CWFC_TID_IND_BIT     4'h4
// First TAG_IDENTIFIER_BANK word of the serial number (bit address 20h)
`define CWFC_TID_SNR_WORD    16'h0002
// ==================================================================
// Configuration word bit positions (MSB first on air, bit 15 = 200h)
`define CWFC_B_TAMPER        4'hF
`define CWFC_B_EXTSUP        4'hE
`define CWFC_B_INVERT        4'hB
`define CWFC_B_TRANS_ON      4'hA
`define CWFC_B_TRANS_RAW     4'h9
`define CWFC_B_STRENGTH      4'h6
`define CWFC_B_OUTLVL        4'h5
`define CWFC_B_RANGE         4'h4
`define CWFC_B_PROT_EPC      4'h2
`define CWFC_B_PROT_TID      4'h1
`define CWFC_B_PSF           4'h0
// Masks of the bit classes
`define CWFC_M_PERSIST       16'h0077
`define CWFC_M_TEMP          16'h0E00
`define CWFC_M_INDICATOR     16'hC000
`define CWFC_M_RFU           16'h3188
// Reset values
`define CWFC_PERSIST_RST     16'h0040
`define CWFC_TEMP_RST        16'h0000
// Field detect pulse length
`define CWFC_PULSE_NS        100
`define CWFC_CLK_MHZ         250
`define CWFC_PULSE_CYC       ((`CWFC_PULSE_NS*`CWFC_CLK_MHZ)/1000)
`define CWFC_PULSE_W         5
// Alarm code width
`define CWFC_ALARM_W         64
`endif

// ===== hdl/cwfc_pkg.sv
package cwfc_pkg;
   // ===============================================================
   // Decoded air command as handed over by the protocol front end
   typedef enum logic [2:0] {
      CWFC_CMD_NONE,
      CWFC_CMD_READ,
      CWFC_CMD_WRITE,
      CWFC_CMD_SELECT,
      CWFC_CMD_TOGGLE,
      CWFC_CMD_PROTECT,
      CWFC_CMD_ALARM
   } cwfc_cmd_type;

   // Memory banks
   typedef enum logic [1:0] {
      CWFC_BANK_RSV = 2'h0,
      CWFC_BANK_EPC = 2'h1,
      CWFC_BANK_TID = 2'h2,
      CWFC_BANK_USR = 2'h3
   } cwfc_bank_type;

   // Access state of the tag
   typedef enum logic [2:0] {
      CWFC_ST_READY,
      CWFC_ST_ARBITRATE,
      CWFC_ST_REPLY,
      CWFC_ST_ACK,
      CWFC_ST_OPEN,
      CWFC_ST_SECURED,
      CWFC_ST_KILLED
   } cwfc_tag_state_type;

   // One request from the front end
   typedef struct packed {
      logic          valid;
      cwfc_cmd_type  cmd;
      cwfc_bank_type bank;
      logic [15:0]   wordPtr;
      logic [15:0]   data;
      logic [15:0]   mask;
   } cwfc_req_type;

   // One answer to the front end
   typedef struct packed {
      logic        valid;
      logic        ok;
      logic        alarm;
      logic [15:0] data;
      logic        match;
   } cwfc_rsp_type;
endpackage : cwfc_pkg

// ===== hdl/cwfc_field_pulse.sv
`timescale 1ns/1ps
`include "cwfc_consts.svh"
// Fixed-length pulse on the rising edge of field presence
module cwfc_field_pulse (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Field presence in, pulse out
   input  wire logic fieldPresent,
   output logic      pulse
);
   logic                    seen_q;
   logic [`CWFC_PULSE_W-1:0] count_q;

   // ===============================================================
   // Edge memory
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else begin
         seen_q <= fieldPresent;
      end
   end

   // Pulse counter, restarted on each field entry
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (fieldPresent && !seen_q) begin
         count_q <= `CWFC_PULSE_W'(`CWFC_PULSE_CYC); // R16
      end else if (count_q != '0) begin
         count_q <= count_q - `CWFC_PULSE_W'(1);
      end
   end

   assign pulse = (count_q != '0);
endmodule : cwfc_field_pulse

// ===== hdl/cwfc_config_word.sv
`timescale 1ns/1ps
`include "cwfc_consts.svh"
// Summary of operation
// R1 - Standard write only while EPC unlocked
// R2 - Toggle command changes flags despite lock
// R3 - Config word lives at EPC word 200h
// R4 - TAG_IDENTIFIER_BANK bit 14h reads as one
// R5 - Separate EPC and serial read protection
// R6 - Protected regions read back as zero
// R7 - Select on protection flags matches protected
// R8 - Legacy protect sets both protection flags
// R9 - Config select only at pointer 200h
// R10 - Alarm query with flag set replies code
// R11 - Select on status flag matches flagged tags
// R12 - Strength default max, cleared means reduced
// R13 - Range flag engages receiver attenuation
// R14 - Range flag selectable
// R15 - Tamper flag follows supply-output loop
// R16 - Field entry emits supply pad pulse
// R17 - Output pad follows stored level
// R18 - Stored level survives kill and supply loss
// R19 - Invert bit changes pad, not stored bit
// R20 - Toggle payload ones flip flags
// R21 - Toggle reply carries current word
// R22 - Toggle only in open or secured
// R23 - Pad equals level xor volatile invert
// R24 - Indicator and reserved bits ignore writes
module cwfc_config_word #(
   parameter logic [`CWFC_ALARM_W-1:0] ALARM_CODE = 64'h0123456789ABCDEF
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Request from the air protocol front end
   input  cwfc_pkg::cwfc_req_type         req,
   input  cwfc_pkg::cwfc_tag_state_type   tagState,
   input  wire logic                      epcLocked,
   input  wire logic                      accessPwdZero,
   // Stored word from non-volatile memory
   input  wire logic                      nvmValid,
   input  wire logic [15:0]               nvmWord,
   input  wire logic [15:0]               memData,
   // Pad and field inputs
   input  wire logic                      loopClosed,
   input  wire logic                      extSupply,
   input  wire logic                      fieldPresent,
   // Answer to the front end
   output cwfc_pkg::cwfc_rsp_type         rsp,
   output logic [`CWFC_ALARM_W-1:0]       alarmCode,
   // Non-volatile update
   output logic                           nvmWrite,
   output logic [15:0]                    nvmData,
   // Pad controls and analogue settings
   output logic                           outPad,
   output logic                           outPadEn,
   output logic                           supplyPulse,
   output logic                           maxStrength,
   output logic                           rxAttenuate
);
   logic [15:0] persist_q;
   logic [15:0] persist_d;
   logic [15:0] temp_q;
   logic [15:0] temp_d;
   logic [15:0] word;
   logic        isCfg;
   logic        cfgWrOk;
   logic        tglApply;
   logic        persistLoad_q;
   cwfc_pkg::cwfc_rsp_type rsp_q;
   logic [`CWFC_ALARM_W-1:0] alarm_q;
   logic        nvmWrite_q;
   logic [15:0] nvmData_q;
   logic        outPad_q;

   // ===============================================================
   // Helpers
   // Writable part of a new word, other bits kept
   function automatic logic [15:0] merge(input logic [15:0] oldV,
                                         input logic [15:0] newV,
                                         input logic [15:0] msk);
      merge = (oldV & ~msk) | (newV & msk);
   endfunction : merge

   // Bit test on the configuration word
   function automatic logic cfgBit(input logic [15:0] w,
                                   input logic [3:0] pos);
      cfgBit = w[pos];
   endfunction : cfgBit

   // Payload applies in secured, or open with zero password
   function automatic logic tglApplies(
      input cwfc_pkg::cwfc_tag_state_type st,
      input logic                         pwdZero);
      tglApplies = (st == cwfc_pkg::CWFC_ST_SECURED) ||
                   (st == cwfc_pkg::CWFC_ST_OPEN && pwdZero);
   endfunction : tglApplies

   // Toggle is answered in open or secured only
   function automatic logic tglAnswered(
      input cwfc_pkg::cwfc_tag_state_type st);
      tglAnswered = (st == cwfc_pkg::CWFC_ST_OPEN) ||
                    (st == cwfc_pkg::CWFC_ST_SECURED);
   endfunction : tglAnswered

   // Indicator bits come live from the pads
   always_comb begin
      word = persist_q | temp_q;
      word[`CWFC_B_TAMPER] = ~loopClosed; // R15
      word[`CWFC_B_EXTSUP] = extSupply;
   end

   // Word decode; the pointer must sit exactly on the word
   assign isCfg = (req.bank == cwfc_pkg::CWFC_BANK_EPC) &&
                  (req.wordPtr == `CWFC_CFG_WORD_ADDR); // R3 R9

   // Standard write reaches the word only while the bank is open
   assign cfgWrOk  = req.valid && req.cmd == cwfc_pkg::CWFC_CMD_WRITE &&
                     isCfg && !epcLocked; // R1
   // Toggle payload is taken as zero outside the allowed states
   assign tglApply = req.valid && req.cmd == cwfc_pkg::CWFC_CMD_TOGGLE &&
                     tglApplies(tagState, accessPwdZero); // R22

   // ===============================================================
   // Next value of the persistent flags
   always_comb begin
      persist_d = persist_q;
      if (req.valid) begin
         case (req.cmd)
            cwfc_pkg::CWFC_CMD_WRITE: begin
               if (cfgWrOk) begin // R1
                  persist_d = merge(persist_q, req.data,
                                    `CWFC_M_PERSIST); // R24
               end
            end
            cwfc_pkg::CWFC_CMD_TOGGLE: begin
               // Open state without a zero password only reports
               if (tglApply) begin // R22
                  persist_d = persist_q ^
                              (req.data & `CWFC_M_PERSIST); // R2 R20
               end
            end
            // Legacy protect ignores the bank lock
            cwfc_pkg::CWFC_CMD_PROTECT: begin
               persist_d[`CWFC_B_PROT_EPC] = 1'b1; // R8
               persist_d[`CWFC_B_PROT_TID] = 1'b1; // R8
            end
            default: begin
               persist_d = persist_q;
            end
         endcase
      end
   end

   // Next value of the volatile flags
   always_comb begin
      temp_d = temp_q;
      // Temporary bits have no write-back; reset clears them
      if (cfgWrOk) begin
         temp_d = merge(temp_q, req.data, `CWFC_M_TEMP); // R24
      end else if (tglApply) begin
         temp_d = temp_q ^ (req.data & `CWFC_M_TEMP); // R20
      end
   end

   // ===============================================================
   // Persistent flags, reloaded from memory after power-up
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         persist_q     <= `CWFC_PERSIST_RST; // R12
         persistLoad_q <= 1'b0;
      end else if (!persistLoad_q) begin
         if (nvmValid) begin
            persist_q     <= nvmWord & `CWFC_M_PERSIST; // R18
            persistLoad_q <= 1'b1;
         end
      end else begin
         persist_q <= persist_d;
      end
   end

   // Volatile flags lost on power loss
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         temp_q <= `CWFC_TEMP_RST; // R23
      end else begin
         temp_q <= temp_d;
      end
   end

   // Write-back to memory whenever a persistent flag changes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nvmWrite_q <= 1'b0;
         nvmData_q  <= 16'h0000;
      end else begin
         nvmWrite_q <= persistLoad_q && (persist_d != persist_q); // R18
         nvmData_q  <= persist_d;
      end
   end

   // ===============================================================
   // Answers: read data, select match, toggle reply, alarm
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q   <= '0;
         alarm_q <= '0;
      end else begin
         rsp_q   <= '0;
         alarm_q <= '0;
         if (req.valid) begin
            case (req.cmd)
               // Protected regions answer zero, the word stays readable
               cwfc_pkg::CWFC_CMD_READ: begin
                  rsp_q.valid <= 1'b1;
                  rsp_q.ok    <= 1'b1;
                  if (isCfg) begin
                     rsp_q.data <= word; // R3
                  end else if (req.bank == cwfc_pkg::CWFC_BANK_EPC &&
                               cfgBit(word, `CWFC_B_PROT_EPC)) begin
                     rsp_q.data <= 16'h0000; // R5 R6
                  end else if (req.bank == cwfc_pkg::CWFC_BANK_TID &&
                               req.wordPtr >= `CWFC_TID_SNR_WORD &&
                               cfgBit(word, `CWFC_B_PROT_TID)) begin
                     rsp_q.data <= 16'h0000; // R5 R6
                  end else if (req.bank == cwfc_pkg::CWFC_BANK_TID &&
                               req.wordPtr == `CWFC_TID_IND_WORD) begin
                     rsp_q.data <= memData |
                        (16'h8000 >> `CWFC_TID_IND_BIT); // R4
                  end else begin
                     rsp_q.data <= memData;
                  end
               end
               cwfc_pkg::CWFC_CMD_WRITE: begin
                  rsp_q.valid <= 1'b1;
                  rsp_q.ok    <= !(isCfg && epcLocked); // R1
               end
               cwfc_pkg::CWFC_CMD_SELECT: begin
                  rsp_q.valid <= 1'b1;
                  rsp_q.ok    <= 1'b1;
                  // Flags match only with pointer at the word R7 R11
                  rsp_q.match <= isCfg &&
                     ((word & req.mask) == (req.data & req.mask)); // R9
               end
               cwfc_pkg::CWFC_CMD_TOGGLE: begin
                  // Reply shows the word after the flip
                  if (tglAnswered(tagState)) begin // R22
                     rsp_q.valid <= 1'b1;
                     rsp_q.ok    <= 1'b1;
                     rsp_q.data  <= (persist_d | temp_d) |
                                    (word & `CWFC_M_INDICATOR); // R21
                  end
               end
               cwfc_pkg::CWFC_CMD_PROTECT: begin
                  rsp_q.valid <= 1'b1;
                  rsp_q.ok    <= 1'b1;
               end
               // Silent while the status flag is clear
               cwfc_pkg::CWFC_CMD_ALARM: begin
                  if (cfgBit(word, `CWFC_B_PSF)) begin
                     rsp_q.valid <= 1'b1; // R10
                     rsp_q.ok    <= 1'b1;
                     rsp_q.alarm <= 1'b1;
                     alarm_q     <= ALARM_CODE; // R10
                  end
               end
               default: begin
                  rsp_q.valid <= 1'b0;
               end
            endcase
         end
      end
   end

   // ===============================================================
   // Output pad, registered to keep glitches off the pin
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outPad_q <= 1'b0;
      end else begin
         outPad_q <= cfgBit(persist_q, `CWFC_B_OUTLVL) ^
                     cfgBit(temp_q, `CWFC_B_INVERT); // R17 R19 R23
      end
   end

   // Field entry pulse on the supply pad
   cwfc_field_pulse u_pulse (
      .clk          (clk),
      .rst_n        (rst_n),
      .fieldPresent (fieldPresent),
      .pulse        (supplyPulse) // R16
   );

   // Port drive; pad enable stays high, the pad is never released
   assign rsp         = rsp_q;
   assign alarmCode   = alarm_q;
   assign nvmWrite    = nvmWrite_q;
   assign nvmData     = nvmData_q;
   assign outPad      = outPad_q;
   assign outPadEn    = 1'b1;
   assign maxStrength = cfgBit(persist_q, `CWFC_B_STRENGTH); // R12
   assign rxAttenuate = cfgBit(persist_q, `CWFC_B_RANGE); // R13 R14
endmodule : cwfc_config_word

// ===== sim/cwfc_config_word_sva.sv
`timescale 1ns/1ps
`include "cwfc_consts.svh"
// ==========
// Port-level checks of the configuration word block
module cwfc_config_word_sva #(
   parameter logic [63:0] ALARM_CODE = 64'h0
) (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    rst_n,
   // Request side
   input cwfc_pkg::cwfc_req_type       req,
   input cwfc_pkg::cwfc_tag_state_type tagState,
   input wire logic                    epcLocked,
   input wire logic                    fieldPresent,
   // Answer, store and pads
   input cwfc_pkg::cwfc_rsp_type       rsp,
   input wire logic [63:0]             alarmCode,
   input wire logic                    nvmWrite,
   input wire logic                    outPad,
   input wire logic                    supplyPulse,
   input wire logic                    maxStrength,
   input wire logic                    rxAttenuate
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   localparam int PCYC = `CWFC_PULSE_CYC;
   logic [7:0] pulseLen_q;
   logic       atCfg;
   logic       isTgl;
   // Decoded requests as seen at the port
   assign atCfg = req.valid && req.bank == cwfc_pkg::CWFC_BANK_EPC
                  && req.wordPtr == `CWFC_CFG_WORD_ADDR;
   assign isTgl = req.valid && req.cmd == cwfc_pkg::CWFC_CMD_TOGGLE;
   // High time of the field pulse, too long to unroll
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseLen_q <= 8'h00;
      end else begin
         pulseLen_q <= supplyPulse ? pulseLen_q + 8'h01 : 8'h00;
      end
   end
   // Toggle reply and store update leave on one edge, then store idles
   sequence sTglStore;
      rsp.valid && nvmWrite ##1 !nvmWrite;
   endsequence
   chk_read_fields: assert property (
      atCfg && req.cmd == cwfc_pkg::CWFC_CMD_READ |=> rsp.valid && rsp.ok
      && rsp.data[6] == maxStrength && rsp.data[4] == rxAttenuate
      && (rsp.data[5] ^ rsp.data[11]) == outPad)
      else $error("config read disagrees with levels");
   chk_locked_write: assert property (
      atCfg && req.cmd == cwfc_pkg::CWFC_CMD_WRITE && epcLocked
      |=> rsp.valid && !rsp.ok)
      else $error("locked write not refused");
   chk_toggle_state: assert property (
      isTgl && !(tagState inside {cwfc_pkg::CWFC_ST_OPEN,
      cwfc_pkg::CWFC_ST_SECURED}) |=> !rsp.valid)
      else $error("toggle answered outside open or secured");
   chk_toggle_store: assert property (
      isTgl && tagState == cwfc_pkg::CWFC_ST_SECURED
      && (req.data & `CWFC_M_PERSIST) != 16'h0000 |=> sTglStore)
      else $error("toggle reply or store update missing");
   chk_select_ptr: assert property (
      req.valid && req.cmd == cwfc_pkg::CWFC_CMD_SELECT
      && req.bank == cwfc_pkg::CWFC_BANK_EPC && req.wordPtr[15:4] == 12'h020
      && req.wordPtr[3:0] != 4'h0 |=> rsp.valid && !rsp.match)
      else $error("select matched off the word pointer");
   chk_protect_reply: assert property (
      req.valid && req.cmd == cwfc_pkg::CWFC_CMD_PROTECT |=> rsp.valid)
      else $error("legacy protect not answered");
   chk_alarm_code: assert property (
      rsp.alarm |-> rsp.valid && alarmCode == ALARM_CODE)
      else $error("alarm code wrong");
   chk_pulse_start: assert property (
      $rose(fieldPresent) |-> ##[1:2] supplyPulse)
      else $error("field pulse late");
   chk_pulse_length: assert property (
      $fell(supplyPulse) |-> pulseLen_q == PCYC)
      else $error("field pulse length wrong");
endmodule : cwfc_config_word_sva

bind cwfc_config_word cwfc_config_word_sva #(.ALARM_CODE(ALARM_CODE))
   u_cwfc_config_word_sva (
   .clk(clk), .rst_n(rst_n), .req(req), .tagState(tagState),
   .epcLocked(epcLocked), .fieldPresent(fieldPresent), .rsp(rsp),
   .alarmCode(alarmCode), .nvmWrite(nvmWrite), .outPad(outPad),
   .supplyPulse(supplyPulse), .maxStrength(maxStrength),
   .rxAttenuate(rxAttenuate));

// ===== sim/cwfc_reader_model.sv
`timescale 1ns/1ps
`include "cwfc_consts.svh"
// ==========
// Interrogator side and non-volatile store
module cwfc_reader_model (
   // Clock
   input wire logic               clk,
   // Air requests and answers
   output cwfc_pkg::cwfc_req_type req,
   input cwfc_pkg::cwfc_rsp_type  rsp,
   // Non-volatile store
   input wire logic               nvmWrite,
   input wire logic [15:0]        nvmData,
   output logic                   nvmValid,
   output logic [15:0]            nvmWord
);
   cwfc_pkg::cwfc_rsp_type lastRsp;
   // Idle request, store at its default
   initial begin
      req = '0;
      nvmValid = 1'b1;
      nvmWord = `CWFC_PERSIST_RST;
   end
   // Store keeps its word across resets of the block
   always @(posedge clk) begin
      if (nvmWrite === 1'b1) begin
         nvmWord <= nvmData;
      end
   end
   // One request, held up to the edge that takes it
   task automatic issue(input cwfc_pkg::cwfc_cmd_type c,
                        input logic [1:0] b, input logic [15:0] p,
                        input logic [15:0] d, input logic [15:0] m);
      @(posedge clk);
      #1;
      req = {1'b1, c, b, p, d, m};
      @(posedge clk);
      #1;
      lastRsp = rsp;
      // Released fields show junk, not the old value
      req = {1'b0, ~req[52:0]};
   endtask : issue
endmodule : cwfc_reader_model

// ===== sim/tb.sv
`timescale 1ns/1ps
`include "cwfc_consts.svh"
// ==========
// Self-checking bench of the configuration word block
module tb;
   localparam logic [63:0] CODE = 64'h1122334455667788; // Arbitrary value
   localparam logic [15:0] CFG = `CWFC_CFG_WORD_ADDR;
   localparam logic [1:0] EPC = 2'h1;
   localparam logic [1:0] TAG_IDENTIFIER_BANK = 2'h2;
   localparam cwfc_pkg::cwfc_cmd_type RD = cwfc_pkg::CWFC_CMD_READ;
   localparam cwfc_pkg::cwfc_cmd_type WR = cwfc_pkg::CWFC_CMD_WRITE;
   localparam cwfc_pkg::cwfc_cmd_type SL = cwfc_pkg::CWFC_CMD_SELECT;
   localparam cwfc_pkg::cwfc_cmd_type TG = cwfc_pkg::CWFC_CMD_TOGGLE;
   localparam cwfc_pkg::cwfc_cmd_type PR = cwfc_pkg::CWFC_CMD_PROTECT;
   localparam cwfc_pkg::cwfc_cmd_type AL = cwfc_pkg::CWFC_CMD_ALARM;
   logic                         clk, rst_n, epcLocked, accessPwdZero;
   logic                         nvmValid, nvmWrite, loopClosed, extSupply;
   logic                         fieldPresent, outPad, padEn, supplyPulse;
   logic                         maxStrength, rxAttenuate;
   logic [15:0]                  nvmWord, nvmData, memData;
   logic [63:0]                  alarmCode, ac;
   cwfc_pkg::cwfc_req_type       req;
   cwfc_pkg::cwfc_rsp_type       rsp, r;
   cwfc_pkg::cwfc_tag_state_type tagState;
   int                           bad_count = 0, total_checks = 0, cyc = 0;

   cwfc_config_word #(.ALARM_CODE(CODE)) u_cwfc_config_word (
      .clk(clk), .rst_n(rst_n), .req(req), .tagState(tagState),
      .epcLocked(epcLocked), .accessPwdZero(accessPwdZero),
      .nvmValid(nvmValid), .nvmWord(nvmWord), .memData(memData),
      .loopClosed(loopClosed), .extSupply(extSupply),
      .fieldPresent(fieldPresent), .rsp(rsp), .alarmCode(alarmCode),
      .nvmWrite(nvmWrite), .nvmData(nvmData), .outPad(outPad),
      .outPadEn(padEn), .supplyPulse(supplyPulse),
      .maxStrength(maxStrength), .rxAttenuate(rxAttenuate));
   cwfc_reader_model u_cwfc_reader_model (
      .clk(clk), .req(req), .rsp(rsp), .nvmWrite(nvmWrite),
      .nvmData(nvmData), .nvmValid(nvmValid), .nvmWord(nvmWord));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard, far above the roughly 130 cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [63:0] s, e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic op(input cwfc_pkg::cwfc_cmd_type c, input logic [1:0] b,
                     input logic [15:0] p, d, m);
      u_cwfc_reader_model.issue(c, b, p, d, m);
      r = u_cwfc_reader_model.lastRsp;
      ac = alarmCode;
   endtask : op
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset
   task automatic t_defaults;
      op(RD, EPC, CFG, 16'h0000, 16'h0000);
      chk("word", r.data, 16'h0040);
      chk("strength", maxStrength, 1'b1);
      chk("padEn", padEn, 1'b1);
      op(RD, TAG_IDENTIFIER_BANK, 16'h0001, 16'h0000, 16'h0000);
      chk("tidFlag", r.data[11], 1'b1);
   endtask : t_defaults
   task automatic t_write;
      op(WR, EPC, CFG, 16'hFFF9, 16'h0000);
      chk("wrOk", r.ok, 1'b1);
      op(RD, EPC, CFG, 16'h0000, 16'h0000);
      chk("wrWord", r.data, 16'h0E71);
      chk("atten", rxAttenuate, 1'b1);
      chk("padXor", outPad, 1'b0);
      op(WR, EPC, CFG, 16'h0000, 16'h0000);
      chk("reduced", maxStrength, 1'b0);
   endtask : t_write
   task automatic t_locked;
      epcLocked = 1'b1;
      op(WR, EPC, CFG, 16'h0040, 16'h0000);
      chk("lockOk", r.ok, 1'b0);
      op(TG, EPC, CFG, 16'h0011, 16'h0000);
      chk("tglWord", r.data, 16'h0011);
      tagState = cwfc_pkg::CWFC_ST_OPEN;
      accessPwdZero = 1'b0;
      op(TG, EPC, CFG, 16'h0011, 16'h0000);
      chk("openWord", r.data, 16'h0011);
      tagState = cwfc_pkg::CWFC_ST_READY;
      op(TG, EPC, CFG, 16'h0011, 16'h0000);
      chk("readyRsp", r.valid, 1'b0);
      tagState = cwfc_pkg::CWFC_ST_SECURED;
      op(TG, EPC, CFG, 16'h0011, 16'h0000);
      chk("backWord", r.data, 16'h0000);
   endtask : t_locked
   task automatic t_protect;
      memData = 16'hA5A5;
      op(PR, EPC, 16'h0000, 16'h0000, 16'h0000);
      op(RD, EPC, 16'h0002, 16'h0000, 16'h0000);
      chk("epcHidden", r.data, 16'h0000);
      op(SL, EPC, CFG, 16'h0006, 16'h0006);
      chk("protSel", r.match, 1'b1);
      op(SL, EPC, 16'h0203, 16'h0000, 16'h0000);
      chk("offPtr", r.match, 1'b0);
      op(TG, EPC, CFG, 16'h0002, 16'h0000);
      op(RD, TAG_IDENTIFIER_BANK, 16'h0002, 16'h0000, 16'h0000);
      chk("tidShown", r.data, 16'hA5A5);
      op(TG, EPC, CFG, 16'h0004, 16'h0000);
      op(RD, EPC, 16'h0002, 16'h0000, 16'h0000);
      chk("epcShown", r.data, 16'hA5A5);
   endtask : t_protect
   task automatic t_psf;
      op(AL, EPC, 16'h0000, 16'h0000, 16'h0000);
      chk("idleAlarm", r.valid, 1'b0);
      op(TG, EPC, CFG, 16'h0001, 16'h0000);
      op(AL, EPC, 16'h0000, 16'h0000, 16'h0000);
      chk("alarm", r.alarm, 1'b1);
      chk("code", ac, CODE);
      op(SL, EPC, CFG, 16'h0001, 16'h0001);
      chk("psfSel", r.match, 1'b1);
      op(TG, EPC, CFG, 16'h0011, 16'h0000);
      op(SL, EPC, CFG, 16'h0010, 16'h0011);
      chk("rangeSel", r.match, 1'b1);
      op(TG, EPC, CFG, 16'h0010, 16'h0000);
   endtask : t_psf
   task automatic t_pads;
      loopClosed = 1'b0;
      extSupply = 1'b1;
      op(RD, EPC, CFG, 16'h0000, 16'h0000);
      chk("tamper", r.data[15:14], 2'h3);
      loopClosed = 1'b1;
      extSupply = 1'b0;
      op(TG, EPC, CFG, 16'h0020, 16'h0000);
      // Pad register follows the word one edge later
      @(posedge clk);
      #1;
      chk("padHigh", outPad, 1'b1);
      op(TG, EPC, CFG, 16'h0800, 16'h0000);
      @(posedge clk);
      #1;
      chk("padInv", outPad, 1'b0);
      chk("lvlKept", r.data[5], 1'b1);
      do_reset();
      op(RD, EPC, CFG, 16'h0000, 16'h0000);
      chk("restored", r.data, 16'h0020);
      chk("padReset", outPad, 1'b1);
   endtask : t_pads
   task automatic t_field;
      int n;
      n = 0;
      fieldPresent = 1'b1;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (supplyPulse === 1'b1) n++;
      end
      chk("pulseLen", n, `CWFC_PULSE_CYC);
      fieldPresent = 1'b0;
   endtask : t_field
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // Main sequence
   initial begin
      tagState = cwfc_pkg::CWFC_ST_SECURED;
      epcLocked = 1'b0;
      accessPwdZero = 1'b1;
      memData = 16'h0000;
      loopClosed = 1'b1;
      extSupply = 1'b0;
      fieldPresent = 1'b0;
      do_reset();
      t_defaults();
      t_write();
      t_locked();
      t_protect();
      t_psf();
      t_pads();
      t_field();
      give_verdict();
   end
endmodule : tb
